// ---- logic/gxi_expander.sv ----
// Purpose: Top of the 16-bit port expander slave: register pairs, pins and interrupt.
// Assumes: clk runs at 100 MHz, far above the serial clock; srst is the power-on reset.
// Notes: Drive strength and pull resistor registers are not held here and read as zero.
`timescale 1ns/1ps
`default_nettype none
module gxi_expander #(
  parameter logic [6:0] DEV_ADDR = 7'h5A
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic srst,
  // External reset pin, active low
  input wire logic rst_pin_n,
  // Serial bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Interrupt line, open drain
  output logic int_o,
  output logic int_oe,
  // Port pins
  input wire logic [15:0] port_i,
  output logic [15:0] port_o,
  output logic [15:0] port_oe
);

  logic rst_m;
  logic rst_s;
  logic rst_all;
  logic [15:0] pin_m;
  logic [15:0] pin_s;
  logic [7:0] ptr;
  logic [15:0] out_reg;
  logic [15:0] pol_reg;
  logic [15:0] cfg_reg;
  logic [15:0] lat_en;
  logic [15:0] msk_reg;
  logic [1:0] odc_reg;
  logic [15:0] snap;
  logic [15:0] lat_flag;
  logic [15:0] lat_val;
  logic [15:0] in_val;
  logic [15:0] pend;
  logic [15:0] status;
  logic [15:0] od_sel;
  logic [1:0] port_read;
  logic wr_hit;
  logic eng_sda_oe;

  gxi_bus_if bus ();

  // Replace one byte of a register pair, chosen by bit 0 of the pointer.
  function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
                                           input logic [7:0] data);
    logic [15:0] res;
    res = old;
    if (hi) begin
      res[15:8] = data;
    end else begin
      res[7:0] = data;
    end
    return res;
  endfunction : put_byte

  // Does the pointer address the pair that holds cmd?
  function automatic logic in_pair(input logic [7:0] p, input logic [7:0] cmd);
    return p[7:1] == cmd[7:1];
  endfunction : in_pair

  // Reset pin and port pins come from outside and pass two flip-flops first.
  always_ff @(posedge clk) begin
    if (srst) begin
      rst_m <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_m <= rst_pin_n;
      rst_s <= rst_m;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_m <= 16'h0000;
      pin_s <= 16'h0000;
    end else begin
      pin_m <= port_i;
      pin_s <= pin_m;
    end
  end

  // One reset for all control state: power-on or pin reset.
  always_ff @(posedge clk) begin
    if (srst) begin
      rst_all <= 1'b1;
    end else begin
      rst_all <= ~rst_s;
    end
  end

  gxi_i2c_engine #(
    .DEV_ADDR(DEV_ADDR)
  ) u_engine (
    .clk(clk),
    .srst(rst_all),
    .scl_pin(scl_i),
    .sda_pin(sda_i),
    .sda_oe(eng_sda_oe),
    .bus(bus.engine)
  );

  assign wr_hit = bus.wr_stb & ~bus.wr_cmd;

  // Register pointer: set by the command byte, then flips within the pair per byte.
  always_ff @(posedge clk) begin
    if (rst_all) begin
      ptr <= gxi_pkg::PTR_RST;
    end else if (bus.wr_stb && bus.wr_cmd) begin
      ptr <= bus.wr_data;
    end else if (wr_hit || bus.rd_stb) begin
      ptr <= {ptr[7:1], ~ptr[0]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      out_reg <= gxi_pkg::OUT_RST;
    end else if (wr_hit && in_pair(ptr, gxi_pkg::CMD_OUT0)) begin
      out_reg <= put_byte(out_reg, ptr[0], bus.wr_data);
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      pol_reg <= gxi_pkg::POL_RST;
    end else if (wr_hit && in_pair(ptr, gxi_pkg::CMD_POL0)) begin
      pol_reg <= put_byte(pol_reg, ptr[0], bus.wr_data);
    end
  end

  // A set bit makes the pin an input.
  always_ff @(posedge clk) begin
    if (rst_all) begin
      cfg_reg <= gxi_pkg::CFG_RST;
    end else if (wr_hit && in_pair(ptr, gxi_pkg::CMD_CFG0)) begin
      cfg_reg <= put_byte(cfg_reg, ptr[0], bus.wr_data);
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      lat_en <= gxi_pkg::LAT_RST;
    end else if (wr_hit && in_pair(ptr, gxi_pkg::CMD_LAT0)) begin
      lat_en <= put_byte(lat_en, ptr[0], bus.wr_data);
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      msk_reg <= gxi_pkg::MSK_RST;
    end else if (wr_hit && in_pair(ptr, gxi_pkg::CMD_MSK0)) begin
      msk_reg <= put_byte(msk_reg, ptr[0], bus.wr_data);
    end
  end

  // The output stage register has no partner; its flipped address is unmapped.
  always_ff @(posedge clk) begin
    if (rst_all) begin
      odc_reg <= gxi_pkg::ODC_RST;
    end else if (wr_hit && ptr == gxi_pkg::CMD_ODC) begin
      odc_reg <= bus.wr_data[1:0];
    end
  end

  // A completed read byte of an input port clears that port's pending changes.
  assign port_read[0] = bus.rd_stb && ptr == gxi_pkg::CMD_IN0;
  assign port_read[1] = bus.rd_stb && ptr == gxi_pkg::CMD_IN1;

  // Per pin change detection against the value last read by the master.
  for (genvar gi = 0; gi < gxi_pkg::PORT_W; gi++) begin : g_pin
    localparam int PORT = gi / 8;

    always_ff @(posedge clk) begin
      if (rst_all) begin
        snap[gi] <= pin_s[gi];
        lat_flag[gi] <= 1'b0;
        lat_val[gi] <= 1'b0;
      end else if (port_read[PORT]) begin
        // The clear absorbs a change in the same cycle, so such a change is not seen.
        snap[gi] <= pin_s[gi];
        lat_flag[gi] <= 1'b0;
      end else if (cfg_reg[gi] && lat_en[gi] && !lat_flag[gi] && (pin_s[gi] != snap[gi])) begin
        lat_flag[gi] <= 1'b1;
        lat_val[gi] <= pin_s[gi];
      end
    end

    // A pin read while latched shows the captured level until the port is read.
    assign in_val[gi] = (lat_en[gi] && lat_flag[gi]) ? lat_val[gi] : pin_s[gi];

    // Output pins are gated by cfg; a pin turned to input with a stale snap still fires.
    assign pend[gi] = cfg_reg[gi] &
                      (lat_en[gi] ? lat_flag[gi] : (pin_s[gi] != snap[gi]));
  end

  assign status = pend & ~msk_reg;

  // Read data for the register under the pointer; unmapped commands read as zero.
  always_comb begin
    case (ptr)
      gxi_pkg::CMD_IN0: bus.tx_data = in_val[7:0] ^ pol_reg[7:0];
      gxi_pkg::CMD_IN1: bus.tx_data = in_val[15:8] ^ pol_reg[15:8];
      gxi_pkg::CMD_OUT0: bus.tx_data = out_reg[7:0];
      gxi_pkg::CMD_OUT1: bus.tx_data = out_reg[15:8];
      gxi_pkg::CMD_POL0: bus.tx_data = pol_reg[7:0];
      gxi_pkg::CMD_POL1: bus.tx_data = pol_reg[15:8];
      gxi_pkg::CMD_CFG0: bus.tx_data = cfg_reg[7:0];
      gxi_pkg::CMD_CFG1: bus.tx_data = cfg_reg[15:8];
      gxi_pkg::CMD_LAT0: bus.tx_data = lat_en[7:0];
      gxi_pkg::CMD_LAT1: bus.tx_data = lat_en[15:8];
      gxi_pkg::CMD_MSK0: bus.tx_data = msk_reg[7:0];
      gxi_pkg::CMD_MSK1: bus.tx_data = msk_reg[15:8];
      gxi_pkg::CMD_STS0: bus.tx_data = status[7:0];
      gxi_pkg::CMD_STS1: bus.tx_data = status[15:8];
      gxi_pkg::CMD_ODC: bus.tx_data = {6'h00, odc_reg};
      default: bus.tx_data = 8'h00;
    endcase
  end

  // Open-drain ports drive only a low level; push-pull ports drive both.
  assign od_sel = {{8{odc_reg[1]}}, {8{odc_reg[0]}}};

  always_ff @(posedge clk) begin
    if (rst_all) begin
      port_o <= gxi_pkg::OUT_RST;
      port_oe <= 16'h0000;
    end else begin
      port_o <= out_reg;
      port_oe <= ~cfg_reg & (~od_sel | ~out_reg);
    end
  end

  // The interrupt pad only ever pulls low; int_o stays at zero.
  always_ff @(posedge clk) begin
    if (rst_all) begin
      int_o <= 1'b0;
      int_oe <= 1'b0;
    end else begin
      int_o <= 1'b0;
      int_oe <= |status;
    end
  end

  // Serial data is open drain as well; the engine's enable is already registered.
  always_ff @(posedge clk) begin
    if (rst_all) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  assign sda_oe = eng_sda_oe;

endmodule : gxi_expander
`default_nettype wire

// ---- logic/gxi_pkg.sv ----
// Purpose: Shared constants of the 16-bit port expander slave.
// Assumes: Command addresses are byte-wide and pairs differ only in bit 0.
// Notes: Reset values of the register pairs live here so both ends agree.
package gxi_pkg;

  // Bus engine states, Gray coded along address, acknowledge and data path.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_AACK  = 3'h3,
    ST_RX    = 3'h2,
    ST_RXACK = 3'h6,
    ST_TX    = 3'h7,
    ST_TXACK = 3'h5
  } gxi_state_e;

  localparam int PORT_W = 16;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Command byte values that select each register.
  localparam logic [7:0] CMD_IN0 = 8'h00;
  localparam logic [7:0] CMD_IN1 = 8'h01;
  localparam logic [7:0] CMD_OUT0 = 8'h02;
  localparam logic [7:0] CMD_OUT1 = 8'h03;
  localparam logic [7:0] CMD_POL0 = 8'h04;
  localparam logic [7:0] CMD_POL1 = 8'h05;
  localparam logic [7:0] CMD_CFG0 = 8'h06;
  localparam logic [7:0] CMD_CFG1 = 8'h07;
  localparam logic [7:0] CMD_LAT0 = 8'h44;
  localparam logic [7:0] CMD_LAT1 = 8'h45;
  localparam logic [7:0] CMD_MSK0 = 8'h4A;
  localparam logic [7:0] CMD_MSK1 = 8'h4B;
  localparam logic [7:0] CMD_STS0 = 8'h4C;
  localparam logic [7:0] CMD_STS1 = 8'h4D;
  localparam logic [7:0] CMD_ODC = 8'h4F;

  // Reset values.
  localparam logic [15:0] OUT_RST = 16'hFFFF;
  localparam logic [15:0] POL_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'hFFFF;
  localparam logic [15:0] LAT_RST = 16'h0000;
  localparam logic [15:0] MSK_RST = 16'hFFFF;
  localparam logic [1:0] ODC_RST = 2'h0;
  localparam logic [7:0] PTR_RST = 8'h00;

endpackage : gxi_pkg

// ---- logic/gxi_bus_if.sv ----
// Purpose: Byte level handshake between the serial engine and the register file.
// Assumes: Both ends run on the same system clock.
// Notes: Strobes are single-cycle pulses; tx_data is read only when a byte is loaded.
`timescale 1ns/1ps
`default_nettype none
interface gxi_bus_if;
  logic wr_stb;
  logic wr_cmd;
  logic [7:0] wr_data;
  logic rd_stb;
  logic [7:0] tx_data;

  modport engine (
    output wr_stb,
    output wr_cmd,
    output wr_data,
    output rd_stb,
    input tx_data
  );

  modport regs (
    input wr_stb,
    input wr_cmd,
    input wr_data,
    input rd_stb,
    output tx_data
  );
endinterface : gxi_bus_if
`default_nettype wire

// ---- logic/gxi_i2c_engine.sv ----
// Purpose: Serial slave engine: start and stop detection, address match, byte shifting.
// Assumes: scl_pin and sda_pin are raw pins; the system clock is far faster than the link.
// Notes: SDA is only ever pulled low, so sda_oe alone carries the data.
`timescale 1ns/1ps
`default_nettype none
module gxi_i2c_engine #(
  parameter logic [6:0] DEV_ADDR = 7'h5A
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_oe,
  // Byte handshake
  gxi_bus_if.engine bus
);

  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  gxi_pkg::gxi_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic rd_mode;
  logic first_byte;
  logic nack;
  logic scl_rise, scl_fall, start_c, stop_c;

  always_ff @(posedge clk) begin
    if (srst) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_pin, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_pin, sda_m, sda_s};
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= gxi_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      sda_oe <= 1'b0;
      rd_mode <= 1'b0;
      first_byte <= 1'b0;
      nack <= 1'b0;
    end else if (start_c) begin
      state <= gxi_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      state <= gxi_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        gxi_pkg::ST_ADDR, gxi_pkg::ST_RX: begin
          if (scl_rise && bit_cnt != gxi_pkg::BYTE_BITS) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == gxi_pkg::BYTE_BITS) begin
            bit_cnt <= 4'h0;
            if (state == gxi_pkg::ST_RX) begin
              sda_oe <= 1'b1;
              state <= gxi_pkg::ST_RXACK;
            end else if (shreg[7:1] == DEV_ADDR) begin
              sda_oe <= 1'b1;
              rd_mode <= shreg[0];
              state <= gxi_pkg::ST_AACK;
            end else begin
              state <= gxi_pkg::ST_IDLE;
            end
          end
        end
        gxi_pkg::ST_AACK, gxi_pkg::ST_RXACK: begin
          if (scl_fall) begin
            if (state == gxi_pkg::ST_RXACK) begin
              first_byte <= 1'b0;
            end else begin
              first_byte <= 1'b1;
            end
            if (rd_mode && state == gxi_pkg::ST_AACK) begin
              shreg <= bus.tx_data;
              sda_oe <= ~bus.tx_data[7];
              bit_cnt <= 4'h1;
              state <= gxi_pkg::ST_TX;
            end else begin
              sda_oe <= 1'b0;
              state <= gxi_pkg::ST_RX;
            end
          end
        end
        gxi_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt == gxi_pkg::BYTE_BITS) begin
              sda_oe <= 1'b0;
              bit_cnt <= 4'h0;
              state <= gxi_pkg::ST_TXACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              sda_oe <= ~shreg[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        gxi_pkg::ST_TXACK: begin
          if (scl_rise) begin
            nack <= sda_s;
          end else if (scl_fall) begin
            if (!nack) begin
              shreg <= bus.tx_data;
              sda_oe <= ~bus.tx_data[7];
              bit_cnt <= 4'h1;
              state <= gxi_pkg::ST_TX;
            end else begin
              state <= gxi_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
          state <= gxi_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Byte strobes towards the register file.
  always_ff @(posedge clk) begin
    if (srst) begin
      bus.wr_stb <= 1'b0;
      bus.wr_cmd <= 1'b0;
      bus.wr_data <= 8'h00;
      bus.rd_stb <= 1'b0;
    end else begin
      bus.wr_stb <= (state == gxi_pkg::ST_RX) && scl_fall && (bit_cnt == gxi_pkg::BYTE_BITS)
                    && !start_c && !stop_c;
      bus.wr_cmd <= first_byte;
      bus.wr_data <= shreg;
      bus.rd_stb <= (state == gxi_pkg::ST_TXACK) && scl_rise && !start_c && !stop_c;
    end
  end

endmodule : gxi_i2c_engine
`default_nettype wire

// ---- testbench/gxi_master_model.sv ----
// Purpose: Bus master model that clocks the serial link and pulls data low.
// Assumes: The data line has a pull-up; the clock idles high between frames.
// Notes: Clock period 80 ns, low 50 ns so the slave answer settles first.
// Notes: Every edge lands on a falling system clock edge, never on the sampling edge.
`timescale 1ns/1ps
`default_nettype none
module gxi_master_model (
  // Wired bus
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic bit_x(input logic b, output logic r);
    #10 sda_rel = b;
    #40 scl = 1'b1;
    #20 r = sda;
    #10 scl = 1'b0;
  endtask : bit_x
  task automatic cond(input logic a, input logic b);
    #10 sda_rel = a;
    #40 scl = 1'b1;
    #40 sda_rel = b;
    #40;
  endtask : cond
  // Called only from idle or inside our own frame, never over another master.
  task automatic start();
    cond(1'b1, 1'b0);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    cond(1'b0, 1'b1);
  endtask : stop
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r);
    end
    bit_x(1'b1, ack);
  endtask : send
  task automatic recv(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, b[i]);
    end
    bit_x(last, r);
  endtask : recv
endmodule : gxi_master_model
`default_nettype wire

// ---- testbench/gxi_expander_chk.sv ----
// Purpose: Port-level assertions for the expander slave.
// Assumes: Bench changes port pins only while the bus is idle.
// Notes: Idle means both bus lines high for more than twelve cycles.
`timescale 1ns/1ps
`default_nettype none
module gxi_expander_chk (
  // Clock and resets
  input wire logic clk,
  input wire logic srst,
  input wire logic rst_pin_n,
  // Serial bus
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Interrupt and port pins
  input wire logic int_o,
  input wire logic int_oe,
  input wire logic [15:0] port_i,
  input wire logic [15:0] port_o,
  input wire logic [15:0] port_oe
);
  logic [7:0] idle_cnt;
  logic [7:0] chg_age;
  logic [15:0] port_prev;
  logic idle;
  assign idle = idle_cnt > 8'h0C;
  always_ff @(posedge clk) begin
    if (srst || !(scl_i && sda_i)) idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hFF) idle_cnt <= idle_cnt + 8'h01;
  end
  always_ff @(posedge clk) begin
    port_prev <= port_i;
    if (srst || port_i != port_prev) chg_age <= 8'h00;
    else if (chg_age != 8'hFF) chg_age <= chg_age + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst || !rst_pin_n);
  sequence por_held; srst [*4]; endsequence
  sequence pin_held; !rst_pin_n [*6]; endsequence
  sequence rst_state; port_o == 16'hFFFF && port_oe == 16'h0000 && !int_oe && !sda_oe; endsequence
  por_defaults_a: assert property (disable iff (1'b0) por_held |-> rst_state)
    else $error("outputs not at defaults under power-on reset");
  pin_defaults_a: assert property (disable iff (1'b0) pin_held |-> rst_state)
    else $error("outputs not at defaults under reset pin");
  open_drain_a: assert property (int_o == 1'b0 && sda_o == 1'b0)
    else $error("open-drain line driven high");
  int_raise_a: assert property ($rose(int_oe) && idle |-> chg_age inside {[8'h01:8'h08]})
    else $error("interrupt raised without a pin change");
  int_drop_a: assert property ($fell(int_oe) && idle |-> chg_age inside {[8'h01:8'h08]})
    else $error("interrupt cleared without a pin return");
  ack_clear_a: assert property ($fell(int_oe) && !idle |->
    $past(scl_i, 3) || $past(scl_i, 4) || $past(scl_i, 5) || $past(scl_i, 6))
    else $error("read clear outside the acknowledge clock");
  scl_high_a: assert property (scl_i [*3] |-> $stable(sda_oe))
    else $error("data changed while clock high");
  idle_quiet_a: assert property (idle |-> !sda_oe && $stable(port_o) && $stable(port_oe))
    else $error("activity while bus idle");
endmodule : gxi_expander_chk
bind gxi_expander gxi_expander_chk u_chk (.clk(clk), .srst(srst), .rst_pin_n(rst_pin_n),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .int_o(int_o),
  .int_oe(int_oe), .port_i(port_i), .port_o(port_o), .port_oe(port_oe));
`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the port expander slave.
// Assumes: Pull-ups on the data and interrupt lines; the master model clocks the bus.
// Notes: Pins change only with the bus idle so interrupt timing stays clear.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [6:0] ADDR = 7'h5A;  // Arbitrary device address.
  logic clk = 1'b0;
  logic srst, rst_pin_n, scl, sda_rel, sda, sda_o, sda_oe, int_o, int_oe, ack;
  logic [15:0] port_i, port_o, port_oe;
  logic [7:0] rb;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  assign sda = sda_rel & ~sda_oe;
  always #5 clk = ~clk;
  gxi_expander #(.DEV_ADDR(ADDR)) dut (.clk(clk), .srst(srst), .rst_pin_n(rst_pin_n),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .int_o(int_o),
    .int_oe(int_oe), .port_i(port_i), .port_o(port_o), .port_oe(port_oe));
  gxi_master_model m (.scl(scl), .sda_rel(sda_rel), .sda(sda));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tx(input logic [7:0] b);
    m.send(b, ack);
    chk({15'h0000, ack}, 16'h0000, "ack");
  endtask : tx
  task automatic open_wr(input logic [7:0] cmd);
    m.start();
    tx({ADDR, 1'b0});
    tx(cmd);
  endtask : open_wr
  task automatic open_rd(input logic [7:0] cmd);
    open_wr(cmd);
    m.start();
    tx({ADDR, 1'b1});
  endtask : open_rd
  task automatic end_tx();
    m.stop();
    repeat (20) @(negedge clk);
  endtask : end_tx
  task automatic rd_chk(input logic last, input logic [7:0] exp, input string what);
    m.recv(last, rb);
    chk({8'h00, rb}, {8'h00, exp}, what);
  endtask : rd_chk
  task automatic pins(input logic [15:0] v);
    @(negedge clk);
    port_i = v;
  endtask : pins
  // Waiting on after a match catches a late or spurious edge as well.
  task automatic int_is(input logic lvl);
    for (int i = 0; i < 20 && int_oe !== lvl; i++) @(negedge clk);
    repeat (10) @(negedge clk);
    chk({15'h0000, int_oe}, {15'h0000, lvl}, "int");
  endtask : int_is
  task automatic t_reset();
    chk(port_o, gxi_pkg::OUT_RST, "out");
    chk(port_oe, ~gxi_pkg::CFG_RST, "oe");
    pins(16'h0010);
    int_is(1'b0);
    pins(16'h0000);
    int_is(1'b0);
    open_wr(gxi_pkg::CMD_OUT1);
    tx(8'hA5);
    tx(8'h5A);
    tx(8'h3C);
    end_tx();
    chk(port_o, 16'h3C5A, "out pair");
    open_wr(gxi_pkg::CMD_CFG1);
    tx(8'hFF);
    tx(8'hF0);
    end_tx();
    chk(port_oe, 16'h000F, "oe");
    $display("test reset and write done");
  endtask : t_reset
  task automatic t_irq();
    open_wr(gxi_pkg::CMD_MSK0);
    tx(8'h00);
    tx(8'h00);
    end_tx();
    pins(16'h0001);
    int_is(1'b0);
    pins(16'h0011);
    int_is(1'b1);
    pins(16'h0001);
    int_is(1'b0);
    pins(16'h0011);
    int_is(1'b1);
    open_rd(gxi_pkg::CMD_IN0);
    rd_chk(1'b0, 8'h11, "in0");
    int_is(1'b0);
    rd_chk(1'b1, 8'h00, "in1");
    m.start();
    tx({ADDR, 1'b1});
    rd_chk(1'b1, 8'h11, "restart");
    end_tx();
    pins(16'h0001);
    int_is(1'b1);
    pins(16'h0011);
    int_is(1'b0);
    $display("test interrupt done");
  endtask : t_irq
  task automatic t_spur_latch();
    pins(16'h0010);
    int_is(1'b0);
    open_wr(gxi_pkg::CMD_CFG0);
    tx(8'hFF);
    end_tx();
    int_is(1'b1);
    open_rd(gxi_pkg::CMD_IN0);
    rd_chk(1'b1, 8'h10, "in0");
    end_tx();
    int_is(1'b0);
    open_wr(gxi_pkg::CMD_LAT0);
    tx(8'h20);
    end_tx();
    pins(16'h0030);
    int_is(1'b1);
    pins(16'h0010);
    int_is(1'b1);
    open_rd(gxi_pkg::CMD_IN0);
    rd_chk(1'b1, 8'h30, "latched");
    end_tx();
    int_is(1'b0);
    $display("test spurious and latch done");
  endtask : t_spur_latch
  // Status, open-drain stage and polarity are decoded but set by no other test.
  task automatic t_status_pol();
    pins(16'h0011);
    int_is(1'b1);
    open_rd(gxi_pkg::CMD_STS0);
    rd_chk(1'b0, 8'h01, "status0");
    rd_chk(1'b1, 8'h00, "status1");
    end_tx();
    int_is(1'b1);
    pins(16'h0010);
    int_is(1'b0);
    open_wr(gxi_pkg::CMD_CFG0);
    tx(8'h00);
    end_tx();
    chk(port_oe, 16'h00FF, "push-pull");
    open_wr(gxi_pkg::CMD_ODC);
    tx(8'h01);
    end_tx();
    chk(port_oe, 16'h00A5, "open-drain");
    open_wr(gxi_pkg::CMD_POL0);
    tx(8'hFF);
    end_tx();
    open_rd(gxi_pkg::CMD_IN0);
    rd_chk(1'b1, 8'hEF, "inverted");
    end_tx();
    $display("test status and polarity done");
  endtask : t_status_pol
  task automatic t_pin_reset();
    @(negedge clk);
    rst_pin_n = 1'b0;
    repeat (6) @(negedge clk);
    chk(port_o, gxi_pkg::OUT_RST, "out");
    chk(port_oe, 16'h0000, "oe");
    rst_pin_n = 1'b1;
    repeat (10) @(negedge clk);
    open_rd(gxi_pkg::CMD_MSK1);
    rd_chk(1'b0, 8'hFF, "mask1");
    rd_chk(1'b1, 8'hFF, "mask0");
    end_tx();
    $display("test pin reset done");
  endtask : t_pin_reset
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  // The whole run needs about 5100 cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("unexpected at %0t: run too long", $time);
      close_out();
    end
  end
  initial begin
    srst = 1'b1;
    rst_pin_n = 1'b1;
    port_i = 16'h0000;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (10) @(negedge clk);
    t_reset();
    t_irq();
    t_spur_latch();
    t_status_pol();
    t_pin_reset();
    close_out();
  end
endmodule : testbench
`default_nettype wire
